/* hdl/stack_pkg.sv */
// Constants for the return-address stack and indirect address decoder.
// Assumes a single core clock domain; shared by the stack memory and top.
package stack_pkg;
	localparam int STACK_DEPTH = 16;
	localparam int PC_WIDTH = 15;
	localparam int PTR_WIDTH = 5;
	localparam logic [4:0] PTR_EMPTY = 5'h1F;
	localparam logic [4:0] PTR_FIRST = 5'h00;
	localparam logic [4:0] PTR_LAST = 5'h0F;
	localparam logic [15:0] TRAD_LAST = 16'h1FFF;
	localparam logic [15:0] LIN_BASE = 16'h2000;
	localparam logic [15:0] LIN_LAST = 16'h29AF;
	localparam logic [12:0] LIN_BANK_BYTES = 13'h0050;
	localparam logic [12:0] GPR_BANK_OFFSET = 13'h0020;
	localparam logic [12:0] BANK_SPAN = 13'h0080;
	localparam logic [12:0] IND0_ADDR = 13'h0000;
	localparam logic [12:0] IND1_ADDR = 13'h0001;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam int PROG_EXTRA_CYCLES = 1;
	typedef enum logic [1:0] {
		IND_IDLE = 2'b00,
		IND_PROG_WAIT = 2'b01,
		IND_DONE = 2'b11
	} ind_state_t;
endpackage

/* hdl/stack_mem.sv */
// Stack storage: sixteen 15-bit entries, one write port, registered read.
// Assumes the caller serialises writes and supplies a legal index.
`timescale 1ns/100ps
`default_nettype none
module stack_mem
	import stack_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH,
	parameter int WIDTH = PC_WIDTH
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Contents are not reset, as in the real stack
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

/* hdl/stack_and_indirect.sv */
// Return-address stack with pointer/top window, plus indirect address decoder.
// Assumes the sequencer gives one push/pop/software request per cycle.
`timescale 1ns/100ps
`default_nettype none
module stack_and_indirect
	import stack_pkg::*;
#(
	parameter int NUM_BANKS = 32
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic PUSH_REQ,
	input wire logic POP_REQ,
	input wire logic [14:0] PUSH_PC,
	output logic [14:0] POP_PC,
	output logic POP_VALID,
	input wire logic STACK_FAULT_RESET_ENABLE,
	input wire logic STACK_POINTER_WR,
	input wire logic [4:0] STACK_POINTER_WDATA,
	output logic [4:0] STACK_POINTER_REG,
	input wire logic STACK_TOP_LOW_WR,
	input wire logic STACK_TOP_HIGH_WR,
	input wire logic [7:0] STACK_TOP_WDATA,
	output logic [7:0] STACK_TOP_LOW_BYTE,
	output logic [6:0] STACK_TOP_HIGH_BYTE,
	input wire logic FLAG_CLEAR_OVF,
	input wire logic FLAG_CLEAR_UNF,
	output logic STACK_OVERFLOW_FLAG,
	output logic STACK_UNDERFLOW_FLAG,
	output logic STACK_FAULT_RESET,
	input wire logic IND_REQ,
	input wire logic IND_WRITE,
	input wire logic [7:0] FILE_SELECT_POINTER_HIGH,
	input wire logic [7:0] FILE_SELECT_POINTER_LOW,
	input wire logic [7:0] IND_WDATA,
	output logic [12:0] DATA_ADDR,
	output logic DATA_RD,
	output logic DATA_WR,
	output logic [7:0] DATA_WDATA,
	input wire logic [7:0] DATA_RDATA,
	output logic [14:0] PROG_ADDR,
	output logic PROG_RD,
	input wire logic [13:0] PROG_RDATA,
	output logic [7:0] IND_RDATA,
	output logic IND_DONE_PULSE
);
	// ---------------------------------------------------------------
	// Stack pointer and storage
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		REG_NONE = 2'b00,
		REG_DATA = 2'b01,
		REG_PROG = 2'b11,
		REG_ZERO = 2'b10
	} region_t;

	logic [4:0] ptr_q;
	logic [4:0] ptr_d;
	logic [14:0] top_q;
	logic mem_we;
	logic [3:0] mem_waddr;
	logic [14:0] mem_wdata;
	logic [14:0] mem_rdata;
	logic [4:0] ptr_inc;
	logic [4:0] ptr_dec;
	logic overflow_ev;
	logic underflow_ev;

	assign ptr_inc = ptr_q + 5'h01;
	assign ptr_dec = ptr_q - 5'h01;
	// Full at 0x0F; empty only at 0x1F, not at the overflow states 0x10 to 0x1E
	assign overflow_ev = PUSH_REQ && (ptr_q == PTR_LAST);
	assign underflow_ev = POP_REQ && !PUSH_REQ && (ptr_q == PTR_EMPTY);

	// Pointer update: fault reset empties, push increments, pop decrements, software loads
	// Fault reset folded in here so the visible pointer and top window follow it
	always_comb begin
		ptr_d = ptr_q;
		if (STACK_FAULT_RESET) begin
			ptr_d = PTR_EMPTY;
		end else if (PUSH_REQ) begin
			ptr_d = ptr_inc;
		end else if (POP_REQ) begin
			ptr_d = ptr_dec;
		end else if (STACK_POINTER_WR) begin
			ptr_d = STACK_POINTER_WDATA;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ptr_q <= PTR_EMPTY;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	// Push writes at the new position; wraps mod 16 to overwrite old entries
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = ptr_q[3:0];
		mem_wdata = top_q;
		if (PUSH_REQ) begin
			mem_we = 1'b1;
			mem_waddr = ptr_inc[3:0];
			mem_wdata = PUSH_PC;
		end else if (!POP_REQ && STACK_TOP_LOW_WR) begin
			mem_we = 1'b1;
			mem_wdata = {top_q[14:8], STACK_TOP_WDATA};
		end else if (!POP_REQ && STACK_TOP_HIGH_WR) begin
			mem_we = 1'b1;
			mem_wdata = {STACK_TOP_WDATA[6:0], top_q[7:0]};
		end
	end

	stack_mem #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_WIDTH)
	) u_mem (
		.clk(CORE_CLK),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(ptr_d[3:0]),
		.rdata(mem_rdata)
	);

	// Registered top entry follows the memory, bypassing the write just made
	logic bypass_q;
	logic [14:0] bypass_data_q;
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			bypass_q <= 1'b0;
			bypass_data_q <= 15'h0000;
		end else begin
			bypass_q <= mem_we && (mem_waddr == ptr_d[3:0]);
			bypass_data_q <= mem_wdata;
		end
	end
	assign top_q = bypass_q ? bypass_data_q : mem_rdata;

	// Pop returns the entry at the current position before decrementing
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			POP_PC <= 15'h0000;
			POP_VALID <= 1'b0;
		end else begin
			POP_VALID <= POP_REQ && !PUSH_REQ;
			if (POP_REQ && !PUSH_REQ) begin
				POP_PC <= top_q;
			end
		end
	end

	// Software-visible pointer and top window
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			STACK_POINTER_REG <= PTR_EMPTY;
			STACK_TOP_LOW_BYTE <= 8'h00;
			STACK_TOP_HIGH_BYTE <= 7'h00;
		end else begin
			STACK_POINTER_REG <= ptr_d;
			STACK_TOP_LOW_BYTE <= top_q[7:0];
			STACK_TOP_HIGH_BYTE <= top_q[14:8];
		end
	end

	// ---------------------------------------------------------------
	// Fault flags and reset request
	// ---------------------------------------------------------------
	// Flags survive the fault reset so software can see the cause; set wins
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			STACK_OVERFLOW_FLAG <= 1'b0;
			STACK_UNDERFLOW_FLAG <= 1'b0;
		end else begin
			if (overflow_ev) begin
				STACK_OVERFLOW_FLAG <= 1'b1;
			end else if (FLAG_CLEAR_OVF) begin
				STACK_OVERFLOW_FLAG <= 1'b0;
			end
			if (underflow_ev) begin
				STACK_UNDERFLOW_FLAG <= 1'b1;
			end else if (FLAG_CLEAR_UNF) begin
				STACK_UNDERFLOW_FLAG <= 1'b0;
			end
		end
	end

	// One-cycle reset request to the device reset logic
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			STACK_FAULT_RESET <= 1'b0;
		end else begin
			STACK_FAULT_RESET <= STACK_FAULT_RESET_ENABLE && (overflow_ev || underflow_ev);
		end
	end

	// ---------------------------------------------------------------
	// Indirect address decoder
	// ---------------------------------------------------------------
	// Pointer is the plain concatenation of its two bytes
	function automatic region_t decode_region(input logic [15:0] a);
		if (a[15]) begin
			decode_region = REG_PROG;
		end else if (a <= TRAD_LAST) begin
			decode_region = (a[6:0] == IND0_ADDR[6:0] || a[6:0] == IND1_ADDR[6:0]) ?
				REG_ZERO : REG_DATA;
		end else if (a >= LIN_BASE && a <= LIN_LAST) begin
			decode_region = REG_DATA;
		end else begin
			decode_region = REG_ZERO;
		end
	endfunction

	logic [15:0] fsr;
	logic [12:0] lin_off;
	logic [12:0] lin_bank;
	logic [12:0] lin_byte;
	logic [12:0] abs_addr;
	logic lin_unimpl;
	region_t region;
	ind_state_t ind_state_q;
	logic prog_sel_q;

	assign fsr = {FILE_SELECT_POINTER_HIGH, FILE_SELECT_POINTER_LOW};
	assign region = decode_region(fsr);
	assign lin_off = fsr[12:0] - LIN_BASE[12:0];
	assign lin_bank = lin_off / LIN_BANK_BYTES;
	assign lin_byte = lin_off % LIN_BANK_BYTES;
	assign lin_unimpl = fsr[13] && (lin_bank >= 13'(NUM_BANKS));
	// Bank block starts past the registers; common RAM never reached
	assign abs_addr = fsr[13] ? 13'(lin_bank * BANK_SPAN + GPR_BANK_OFFSET + lin_byte) :
		fsr[12:0];

	// Sequence: zero answers take one cycle, data two, program three
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ind_state_q <= IND_IDLE;
			prog_sel_q <= 1'b0;
			DATA_ADDR <= 13'h0000;
			DATA_RD <= 1'b0;
			DATA_WR <= 1'b0;
			DATA_WDATA <= 8'h00;
			PROG_ADDR <= 15'h0000;
			PROG_RD <= 1'b0;
			IND_RDATA <= READ_ZERO;
			IND_DONE_PULSE <= 1'b0;
		end else begin
			DATA_RD <= 1'b0;
			DATA_WR <= 1'b0;
			PROG_RD <= 1'b0;
			IND_DONE_PULSE <= 1'b0;
			case (ind_state_q)
				IND_IDLE: begin
					if (IND_REQ) begin
						DATA_ADDR <= abs_addr;
						DATA_WDATA <= IND_WDATA;
						PROG_ADDR <= fsr[14:0];
						if (region == REG_PROG) begin
							PROG_RD <= !IND_WRITE;
							prog_sel_q <= 1'b1;
							ind_state_q <= IND_PROG_WAIT;
						end else if (region == REG_DATA && !lin_unimpl) begin
							prog_sel_q <= 1'b0;
							DATA_RD <= !IND_WRITE;
							DATA_WR <= IND_WRITE;
							ind_state_q <= IND_DONE;
						end else begin
							IND_RDATA <= READ_ZERO;
							IND_DONE_PULSE <= 1'b1;
						end
					end
				end
				IND_PROG_WAIT: begin
					// Extra cycle: the program word lands a cycle after its strobe
					ind_state_q <= IND_DONE;
				end
				IND_DONE: begin
					IND_RDATA <= prog_sel_q ? PROG_RDATA[7:0] : DATA_RDATA;
					IND_DONE_PULSE <= 1'b1;
					ind_state_q <= IND_IDLE;
				end
				default: begin
					ind_state_q <= IND_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* verification/far_mem.sv */
// Far-side data RAM and program ROM; data answers while its strobe stands,
// program words one cycle after their strobe.
// Assumes strobes come from the indirect decoder; ROM words derive from address.
`timescale 1ns/100ps
`default_nettype none
module far_mem (
	input wire logic clk,
	input wire logic [12:0] daddr,
	input wire logic drd,
	input wire logic dwr,
	input wire logic [7:0] dwd,
	output logic [7:0] drdata,
	input wire logic [14:0] paddr,
	input wire logic prd,
	output logic [13:0] prdata
);
	logic [7:0] mem [8192];
	// Known fill so reads are predictable
	initial for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'hA5;
	// Data read is asynchronous; idle lines invert, so stale data never looks valid
	assign drdata = drd ? mem[daddr] : ~mem[daddr];
	// Program word arrives a cycle late, covered by the extra access cycle
	always @(posedge clk) begin
		if (dwr) mem[daddr] <= dwd;
		prdata <= prd ? paddr[13:0] ^ 14'h1555 : ~prdata;
	end
endmodule
`default_nettype wire

/* verification/stack_chk_sva.sv */
// Checker for pointer moves, stack flags and indirect decode timing.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module stack_chk (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic PUSH_REQ,
	input wire logic POP_REQ,
	input wire logic STACK_FAULT_RESET_ENABLE,
	input wire logic [4:0] STACK_POINTER_REG,
	input wire logic STACK_OVERFLOW_FLAG,
	input wire logic STACK_UNDERFLOW_FLAG,
	input wire logic STACK_FAULT_RESET,
	input wire logic IND_REQ,
	input wire logic IND_WRITE,
	input wire logic [7:0] FILE_SELECT_POINTER_HIGH,
	input wire logic [7:0] FILE_SELECT_POINTER_LOW,
	input wire logic [12:0] DATA_ADDR,
	input wire logic DATA_RD,
	input wire logic DATA_WR,
	input wire logic [7:0] IND_RDATA,
	input wire logic IND_DONE_PULSE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// Decoded request kinds; push wins over pop
	wire logic pop = POP_REQ && !PUSH_REQ;
	wire logic rd0 = IND_REQ && !IND_WRITE && FILE_SELECT_POINTER_HIGH == 8'h00;
	wire logic [4:0] p = STACK_POINTER_REG;
	wire logic flt = (PUSH_REQ && p == 5'h0F) || (pop && p == 5'h1F);
	property p_push; !STACK_FAULT_RESET && PUSH_REQ && p != 5'h0F |=> p == $past(p) + 5'd1;
	endproperty
	a_push: assert property (p_push) else $error("push did not step pointer up");
	property p_pop; !STACK_FAULT_RESET && pop && p != 5'h1F |=> p == $past(p) - 5'd1;
	endproperty
	a_pop: assert property (p_pop) else $error("pop did not step pointer down");
	property p_ovf; PUSH_REQ && p == 5'h0F |=> STACK_OVERFLOW_FLAG; endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag missing");
	property p_unf; pop && p == 5'h1F |=> STACK_UNDERFLOW_FLAG; endproperty
	a_unf: assert property (p_unf) else $error("underflow flag missing");
	property p_frst; flt && STACK_FAULT_RESET_ENABLE |=> STACK_FAULT_RESET; endproperty
	a_frst: assert property (p_frst) else $error("fault reset missing");
	property p_data;
		rd0 && FILE_SELECT_POINTER_LOW[6:1] != 6'h00 |=> DATA_RD
			&& DATA_ADDR == {5'h00, $past(FILE_SELECT_POINTER_LOW)} ##1 IND_DONE_PULSE;
	endproperty
	a_data: assert property (p_data) else $error("direct data read wrong");
	property p_port; rd0 && FILE_SELECT_POINTER_LOW[6:1] == 6'h00 |=>
		(IND_DONE_PULSE && IND_RDATA == 8'h00); endproperty
	a_port: assert property (p_port) else $error("port self read not zero");
	property p_prog; IND_REQ && !IND_WRITE && FILE_SELECT_POINTER_HIGH[7] |=>
		!IND_DONE_PULSE ##1 !IND_DONE_PULSE ##1 IND_DONE_PULSE; endproperty
	a_prog: assert property (p_prog) else $error("program read timing wrong");
	property p_pwr; IND_REQ && IND_WRITE && FILE_SELECT_POINTER_HIGH[7] |=> !DATA_WR [*3];
	endproperty
	a_pwr: assert property (p_pwr) else $error("program write reached data");
	c_ovf: cover property (PUSH_REQ && p == 5'h0F);
	c_frst: cover property (flt && STACK_FAULT_RESET_ENABLE);
	c_prog: cover property (IND_REQ && FILE_SELECT_POINTER_HIGH[7]);
endmodule
bind stack_and_indirect stack_chk stack_chk_inst (.*);
`default_nettype wire

/* verification/tb_stack_and_indirect.sv */
// Self-checking bench: stack push, pop, wrap, faults and indirect access.
// Assumes far_mem answers data reads at once and program reads a cycle late.
`timescale 1ns/100ps
`default_nettype none
module tb_stack_and_indirect;
	import stack_pkg::*;
	logic clk = 0, rst_n = 0, push = 0, pop = 0, fre = 0, spw = 0, tlw = 0, thw = 0;
	logic clro = 0, clru = 0, ireq = 0, iwr = 0, pv, ovf, unf, frst, drs, dwr, prs, done;
	logic [14:0] ppc = 0, popc, paddr;
	logic [4:0] spwd = 0, sp, pm;
	logic [7:0] tw = 0, tl, fh = 0, fl = 0, iwd = 0, dwd, drd, ird, got, d;
	logic [7:0] lf = 8'd95;
	logic [6:0] th;
	logic [12:0] daddr;
	logic [13:0] prd;
	logic [15:0] a;
	logic [14:0] sm [16];
	int errors = 0, comparisons = 0;
	stack_and_indirect stack_and_indirect_inst (.CORE_CLK(clk), .RST_N(rst_n),
		.PUSH_REQ(push), .POP_REQ(pop), .PUSH_PC(ppc), .POP_PC(popc), .POP_VALID(pv),
		.STACK_FAULT_RESET_ENABLE(fre), .STACK_POINTER_WR(spw), .STACK_POINTER_WDATA(spwd),
		.STACK_POINTER_REG(sp), .STACK_TOP_LOW_WR(tlw), .STACK_TOP_HIGH_WR(thw),
		.STACK_TOP_WDATA(tw), .STACK_TOP_LOW_BYTE(tl), .STACK_TOP_HIGH_BYTE(th),
		.FLAG_CLEAR_OVF(clro), .FLAG_CLEAR_UNF(clru), .STACK_OVERFLOW_FLAG(ovf),
		.STACK_UNDERFLOW_FLAG(unf), .STACK_FAULT_RESET(frst), .IND_REQ(ireq),
		.IND_WRITE(iwr), .FILE_SELECT_POINTER_HIGH(fh), .FILE_SELECT_POINTER_LOW(fl),
		.IND_WDATA(iwd), .DATA_ADDR(daddr), .DATA_RD(drs), .DATA_WR(dwr), .DATA_WDATA(dwd),
		.DATA_RDATA(drd), .PROG_ADDR(paddr), .PROG_RD(prs), .PROG_RDATA(prd),
		.IND_RDATA(ird), .IND_DONE_PULSE(done));
	far_mem far_mem_inst (.clk(clk), .daddr(daddr), .drd(drs), .dwr(dwr), .dwd(dwd),
		.drdata(drd), .paddr(paddr), .prd(prs), .prdata(prd));
	initial forever #25 clk = ~clk;
	// Watchdog sized well beyond the short test sequence
	initial begin
		#(50 * 3000);
		errors++;
		results();
	end
	// Repeatable pseudo-random bytes
	function automatic logic [7:0] rnd();
		lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
		return lf;
	endfunction
	// Linear offset to banked absolute address
	function automatic logic [12:0] lin(input logic [15:0] x);
		logic [12:0] o;
		o = 13'(x - LIN_BASE);
		return (o / 13'd80) * BANK_SPAN + GPR_BANK_OFFSET + (o % 13'd80);
	endfunction
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic do_push(input logic [14:0] v);
		push = 1;
		ppc = v;
		tick();
		push = 0;
		pm++;
		sm[pm[3:0]] = v;
		chk(16'(sp), 16'(pm), "pointer after push");
		tick();
	endtask
	task automatic do_pop();
		pop = 1;
		tick();
		pop = 0;
		chk(16'(pv), 16'h0001, "pop valid");
		chk(16'(popc), 16'(sm[pm[3:0]]), "popped value");
		pm--;
		chk(16'(sp), 16'(pm), "pointer after pop");
		tick();
	endtask
	// One indirect access; waits for done under a bound
	task automatic ind(input logic w, input logic [15:0] x, input logic [7:0] v);
		int n;
		n = 0;
		iwr = w;
		{fh, fl} = x;
		iwd = v;
		ireq = 1;
		tick();
		ireq = 0;
		while (done !== 1'b1 && n < 8) begin
			tick();
			n++;
		end
		got = ird;
		if (n == 8) chk(16'(done), 16'h0001, "no done");
		tick();
	endtask
	task automatic results();
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		#1 rst_n = 1;
		pm = PTR_EMPTY;
		chk(16'(sp), 16'h001F, "reset pointer");
		for (int i = 0; i < 17; i++) do_push(15'({rnd(), rnd()}));
		tick();
		chk(16'({th, tl}), 16'(sm[pm[3:0]]), "top after wrap");
		chk(16'(ovf), 16'h0001, "overflow flag");
		do_pop();
		spwd = 5'h03;
		spw = 1;
		tick();
		spw = 0;
		pm = 5'h03;
		tick();
		chk(16'({th, tl}), 16'(sm[3]), "top at pointer");
		tw = rnd();
		tlw = 1;
		tick();
		tlw = 0;
		sm[3][7:0] = tw;
		tw = rnd();
		thw = 1;
		tick();
		thw = 0;
		sm[3][14:8] = tw[6:0];
		tick();
		while (pm != PTR_EMPTY) do_pop();
		clro = 1;
		clru = 1;
		tick();
		clro = 0;
		clru = 0;
		chk(16'({ovf, unf}), 16'h0000, "flags cleared");
		fre = 1;
		pop = 1;
		tick();
		pop = 0;
		chk(16'({unf, frst}), 16'h0003, "underflow reset");
		fre = 0;
		repeat (2) tick();
		chk(16'(sp), 16'h001F, "pointer after fault reset");
		ind(0, 16'h0F02, 0);
		chk(16'(got), 16'h00A7, "direct read");
		for (int i = 0; i < 9; i++) begin
			a = (i == 0) ? LIN_LAST : (i == 1) ? LIN_BASE :
				LIN_BASE + 16'({rnd(), rnd()} % 16'h09B0);
			d = rnd();
			ind(1, a, d);
			ind(0, {3'b000, lin(a)}, 0);
			chk(16'(got), 16'(d), "linear alias");
		end
		ind(0, 16'h0081, 0);
		chk(16'(got), 16'h0000, "port self read");
		ind(0, 16'h29B0, 0);
		chk(16'(got), 16'h0000, "gap read");
		ind(1, 16'hC000, 8'h77);
		for (int i = 0; i < 4; i++) begin
			a = 16'h8000 | {rnd(), rnd()};
			ind(0, a, 0);
			chk(16'(got), 16'(a[7:0] ^ 8'h55), "program read");
		end
		results();
	end
endmodule
`default_nettype wire
